// ==== design/valve_cmd_pkg.sv ====
// Constants shared by the valve command register bank and its helpers.
// Assumes a 10 MHz system clock and 16-bit register numbers on the port.
package valve_cmd_pkg;

	// ========================================================
	// Register numbers, as seen on the register access port.
	// ========================================================
	localparam logic [15:0] ADDR_TC_HOT_RESULT   = 16'h0082;
	localparam logic [15:0] ADDR_TC_COLD_RESULT  = 16'h0083;
	localparam logic [15:0] ADDR_FLUSH_STATUS    = 16'h0124;
	localparam logic [15:0] ADDR_USAGE_SINCE     = 16'h012A;
	localparam logic [15:0] ADDR_REC_FIRST_INDEX = 16'h0130;
	localparam logic [15:0] ADDR_REC_COUNT       = 16'h0131;
	localparam logic [15:0] ADDR_DISINF_ARM      = 16'h0132;
	localparam logic [15:0] ADDR_DISINF_TRIGGER  = 16'h0133;
	localparam logic [15:0] ADDR_DISINF_ABORT    = 16'h0134;
	localparam logic [15:0] ADDR_VALVE_RESET     = 16'h0135;
	localparam logic [15:0] ADDR_TC_TRIGGER      = 16'h0136;
	localparam logic [15:0] ADDR_VALVE_DISABLE   = 16'h0139;
	localparam logic [15:0] ADDR_TC_ARM          = 16'h013C;
	localparam logic [15:0] ADDR_DUTY_TRIGGER    = 16'h013F;
	localparam logic [15:0] ADDR_COLD_TRIGGER    = 16'h0140;
	localparam logic [15:0] ADDR_POST_COLD_TIME  = 16'h0156;
	localparam logic [15:0] ADDR_COLD_SCHED_TYPE = 16'h0159;
	localparam logic [15:0] ADDR_COLD_ACT_TIME   = 16'h015A;

	// ========================================================
	// Command keys and values.
	// ========================================================
	localparam logic [15:0] KEY_DISINFECTION = 16'h5452;
	localparam logic [15:0] KEY_TEMP_CHECK   = 16'h4354;
	localparam logic [15:0] KEY_DUTY_FLUSH   = 16'h4466;
	localparam logic [15:0] KEY_COLD_FLUSH   = 16'h6346;
	localparam logic [15:0] CMD_ONE          = 16'h0001;

	// ========================================================
	// Duty flush status codes.
	// ========================================================
	localparam logic [2:0] FLUSH_OK           = 3'h0;
	localparam logic [2:0] FLUSH_NO_HOT       = 3'h2;
	localparam logic [2:0] FLUSH_NO_FLOW      = 3'h3;
	localparam logic [2:0] FLUSH_CANCELLED    = 3'h4;
	localparam logic [2:0] FLUSH_NOT_REQUIRED = 3'h6;

	// ========================================================
	// Answer codes on the access port.
	// ========================================================
	localparam logic [7:0] EXC_NONE         = 8'h00;
	localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
	localparam logic [7:0] EXC_ILLEGAL_DATA = 8'h03;

	// ========================================================
	// Limits, sizes and reset values.
	// ========================================================
	localparam logic [15:0] ACT_TIME_MAX      = 16'h059F;
	localparam logic [15:0] POST_COLD_MAX     = 16'h0258;
	localparam logic [15:0] REC_SLOTS         = 16'h0064;
	localparam logic [15:0] RST_WORD          = 16'h0000;
	localparam logic [15:0] COUNT_MAX         = 16'hFFFF;

	// ========================================================
	// Timing.
	// ========================================================
	localparam int SECOND_NS         = 1000000000;
	localparam int CLK_PERIOD_NS     = 100;
	localparam int CYCLES_PER_SECOND = SECOND_NS / CLK_PERIOD_NS;

	// Temperature check sequence states.
	typedef enum logic [1:0] {
		TC_IDLE = 2'b00,
		TC_HOT  = 2'b01,
		TC_COLD = 2'b10
	} tc_state_t;

	// True when a written word carries exactly the expected key.
	function automatic logic key_ok(input logic [15:0] data,
	                                input logic [15:0] key);
		key_ok = (data == key);
	endfunction

	// True when a written word lies within 0..max inclusive.
	function automatic logic in_range(input logic [15:0] data,
	                                  input logic [15:0] max);
		in_range = (data <= max);
	endfunction

endpackage

// ==== design/arm_trigger.sv ====
// One arm-then-trigger command pair with a keyed trigger word.
// Assumes write strobes are one-cycle pulses on the system clock.
`timescale 1ns/100ps
module arm_trigger
	import valve_cmd_pkg::*;
#(
	parameter logic [15:0] KEY = 16'h0000
) (
	input  wire logic        clk_sys,   // System clock.
	input  wire logic        rst,       // Synchronous reset, high.
	input  wire logic        ce,        // Clock enable.
	input  wire logic        arm_wr,    // Write to the arming register.
	input  wire logic        arm_allow, // Arming is permitted now.
	input  wire logic        trig_wr,   // Write to the trigger register.
	input  wire logic [15:0] trig_data, // Word written to the trigger.
	input  wire logic        cancel,    // Drop a pending arm.
	output logic             armed,     // Arm is pending.
	output logic             fire       // Trigger accepted this cycle.
);

	// ========================================================
	// State.
	// ========================================================
	typedef struct packed {
		logic armed; // Pending arm, waiting for its key.
	} arm_state_t;

	arm_state_t st;      // Registered state.
	arm_state_t next_st; // Next state.

	// The trigger fires only with the right key on an armed pair.
	assign fire  = trig_wr && st.armed && key_ok(trig_data, KEY);
	assign armed = st.armed;

	// Arming is one-shot: a fire or a cancel consumes it.
	always_comb begin
		next_st = st;
		if (fire || cancel) begin
			next_st.armed = 1'b0;
		end
		if (arm_wr && arm_allow) begin
			next_st.armed = 1'b1;
		end
	end

	// State register.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

endmodule

// ==== design/usage_timer.sv ====
// Whole seconds of outlet activity since the last clear.
// Assumes the activity level comes from logic on the same clock.
`timescale 1ns/100ps
module usage_timer
	import valve_cmd_pkg::*;
#(
	parameter int CYCLES_PER_SEC = CYCLES_PER_SECOND
) (
	input  wire logic        clk_sys, // System clock.
	input  wire logic        rst,     // Synchronous reset, high.
	input  wire logic        ce,      // Clock enable.
	input  wire logic        active,  // Outlet is running water.
	input  wire logic        clear,   // Restart the count.
	output logic [15:0]      seconds  // Seconds counted, saturating.
);

	// ========================================================
	// State.
	// ========================================================
	typedef struct packed {
		logic [23:0] tick; // Cycles of activity in this second.
		logic [15:0] secs; // Whole seconds counted.
	} usage_state_t;

	usage_state_t st;      // Registered state.
	usage_state_t next_st; // Next state.

	assign seconds = st.secs;

	// Partial seconds carry over idle gaps, so short bursts add up.
	always_comb begin
		next_st = st;
		if (clear) begin
			next_st = '0;
		end else if (active) begin
			if (st.tick == 24'(CYCLES_PER_SEC - 1)) begin
				next_st.tick = '0;
				if (st.secs != COUNT_MAX) begin
					next_st.secs = st.secs + 16'h0001;
				end
			end else begin
				next_st.tick = st.tick + 24'h000001;
			end
		end
	end

	// State register.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

endmodule

// ==== design/valve_command_register_map.sv ====
// Holding-register bank of a networked outlet valve: flush bookkeeping,
// keyed commands, valve disable and cold flush scheduling settings.
// Assumes serial framing sits outside and issues one-cycle register
// reads and writes on clk_sys; the valve controller shares the clock.
//
// Function
// - Status code 6 on skipped smart flush.
// - Read-only seconds of usage since flush.
// - Register holds index of latest flush record.
// - Register counts flush records written.
// - Disinfection arming accepted only when enabled.
// - Keyed trigger starts disinfection only when armed.
// - Writing one aborts running disinfection.
// - Writing one resets the valve.
// - Keyed temperature check trigger needs prior arm.
// - Check drives hot, cold, stores results.
// - Cold flush key triggers and commits settings.
// - Cold flush type disables or enables schedule.
// - Register holds cold flush activation minutes.
// - Status code 2 on warm-up timeout.
`timescale 1ns/100ps
module valve_command_register_map
	import valve_cmd_pkg::*;
#(
	parameter int CYCLES_PER_SEC = CYCLES_PER_SECOND
) (
	input  wire logic        clk_sys,          // System clock, 10 MHz.
	input  wire logic        rst,              // Synchronous reset.
	input  wire logic        ce,               // Clock enable.
	// Register access from the framing logic.
	input  wire logic        reg_rd,           // Read request pulse.
	input  wire logic        reg_wr,           // Write request pulse.
	input  wire logic [15:0] reg_addr,         // Register number.
	input  wire logic [15:0] reg_wdata,        // Write data.
	output logic [15:0]      reg_rdata,        // Read data.
	output logic             reg_ack,          // Answer pulse.
	output logic [7:0]       reg_exc,          // Answer code.
	// Status from the valve controller.
	input  wire logic        disinf_enabled,   // Disinfection configured.
	input  wire logic        disinf_done,      // Disinfection finished.
	input  wire logic        outlet_active,    // Water is running.
	input  wire logic        flush_end,        // Duty flush ended.
	input  wire logic        flush_skipped,    // Smart flush not needed.
	input  wire logic        flush_no_hot,     // Warm-up timed out.
	input  wire logic        flush_no_flow,    // No flow seen.
	input  wire logic        flush_cancelled,  // User interrupted.
	input  wire logic        tc_sample,        // Measurement ready.
	input  wire logic [15:0] tc_temp,          // Measured value.
	// Commands to the valve controller.
	output logic             disinf_start,     // Begin disinfection.
	output logic             disinf_stop,      // Abort disinfection.
	output logic             disinf_running,   // Disinfection active.
	output logic             valve_reset,      // Reset the valve.
	output logic             duty_flush_start, // Begin duty flush.
	output logic             cold_flush_start, // Begin cold flush.
	output logic             tc_drive_hot,     // Outlet at full hot.
	output logic             tc_drive_cold,    // Outlet at full cold.
	output logic             valve_disabled,   // Valve held disabled.
	output logic             cold_sched_on,    // Scheduling enabled.
	output logic [10:0]      cold_act_minutes, // Activation time.
	output logic [15:0]      post_cold_secs    // Post cold flush time.
);

	// ========================================================
	// State.
	// ========================================================
	typedef struct packed {
		logic [15:0] rdata;     // Read answer.
		logic        ack;       // Answer strobe.
		logic [7:0]  exc;       // Answer code.
		logic [2:0]  fstatus;   // Last duty flush outcome.
		logic [15:0] rec_index; // Slot of latest flush record.
		logic [15:0] rec_count; // Records written so far.
		logic        d_start;   // Disinfection start pulse.
		logic        d_stop;    // Disinfection abort pulse.
		logic        d_run;     // Disinfection running.
		logic        v_reset;   // Valve reset pulse.
		logic        duty_go;   // Duty flush start pulse.
		logic        cold_go;   // Cold flush start pulse.
		tc_state_t   tc;        // Temperature check phase.
		logic        tc_hot;    // Full hot drive.
		logic        tc_cold;   // Full cold drive.
		logic [15:0] tc_hot_r;  // Hot result.
		logic [15:0] tc_cold_r; // Cold result.
		logic        dis;       // Valve disable.
		logic [15:0] post_p;    // Pending post cold flush time.
		logic [15:0] post_c;    // Committed post cold flush time.
		logic        sched_p;   // Pending schedule type.
		logic        sched_c;   // Committed schedule type.
		logic [10:0] act_p;     // Pending activation minutes.
		logic [10:0] act_c;     // Committed activation minutes.
	} ctl_t;

	ctl_t st;      // Registered state.
	ctl_t next_st; // Next state.

	// ========================================================
	// Helpers.
	// ========================================================
	logic        wr_d_arm;   // Write to disinfection arm.
	logic        wr_d_trig;  // Write to disinfection trigger.
	logic        wr_tc_arm;  // Write to temperature check arm.
	logic        wr_tc_trig; // Write to temperature check trigger.
	logic        d_fire;     // Disinfection trigger accepted.
	logic        tc_fire;    // Temperature check trigger accepted.
	logic        d_armed;    // Disinfection armed.
	logic        tc_armed;   // Temperature check armed.
	logic [15:0] usage_s;    // Usage seconds.

	assign wr_d_arm   = reg_wr && (reg_addr == ADDR_DISINF_ARM);
	assign wr_d_trig  = reg_wr && (reg_addr == ADDR_DISINF_TRIGGER);
	assign wr_tc_arm  = reg_wr && (reg_addr == ADDR_TC_ARM);
	assign wr_tc_trig = reg_wr && (reg_addr == ADDR_TC_TRIGGER);

	// Disinfection pair; arming is refused unless configured.
	arm_trigger #(.KEY(KEY_DISINFECTION)) u_disinf_arm (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.ce        (ce),
		.arm_wr    (wr_d_arm),
		.arm_allow (disinf_enabled),
		.trig_wr   (wr_d_trig),
		.trig_data (reg_wdata),
		.cancel    (st.d_stop),
		.armed     (d_armed),
		.fire      (d_fire)
	);

	// Temperature check pair; a busy check refuses a new arm.
	arm_trigger #(.KEY(KEY_TEMP_CHECK)) u_tcheck_arm (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.ce        (ce),
		.arm_wr    (wr_tc_arm),
		.arm_allow (st.tc == TC_IDLE),
		.trig_wr   (wr_tc_trig),
		.trig_data (reg_wdata),
		.cancel    (1'b0),
		.armed     (tc_armed),
		.fire      (tc_fire)
	);

	// Usage clock restarts whenever a duty flush cycle ends.
	usage_timer #(.CYCLES_PER_SEC(CYCLES_PER_SEC)) u_usage (
		.clk_sys (clk_sys),
		.rst     (rst),
		.ce      (ce),
		.active  (outlet_active),
		.clear   (flush_end),
		.seconds (usage_s)
	);

	// ========================================================
	// Next-state logic.
	// ========================================================
	// Register access, controller events and command pulses. Pulses
	// last one cycle; a controller event in the cycle of a register
	// access is still taken, except a done pulse that meets a disinfection start.
	always_comb begin
		next_st         = st;
		next_st.ack     = 1'b0;
		next_st.d_start = 1'b0;
		next_st.d_stop  = 1'b0;
		next_st.v_reset = 1'b0;
		next_st.duty_go = 1'b0;
		next_st.cold_go = 1'b0;

		// Flush outcome and record bookkeeping.
		if (flush_end) begin
			if (flush_skipped) begin
				next_st.fstatus = FLUSH_NOT_REQUIRED;
			end else if (flush_no_hot) begin
				next_st.fstatus = FLUSH_NO_HOT;
			end else if (flush_no_flow) begin
				next_st.fstatus = FLUSH_NO_FLOW;
			end else if (flush_cancelled) begin
				next_st.fstatus = FLUSH_CANCELLED;
			end else begin
				next_st.fstatus = FLUSH_OK;
			end
			// The record list is circular; the index follows the newest.
			if (st.rec_count == RST_WORD) begin
				next_st.rec_index = RST_WORD;
			end else if (st.rec_index == REC_SLOTS - 16'h0001) begin
				next_st.rec_index = RST_WORD;
			end else begin
				next_st.rec_index = st.rec_index + 16'h0001;
			end
			if (st.rec_count != COUNT_MAX) begin
				next_st.rec_count = st.rec_count + 16'h0001;
			end
		end

		// Disinfection start and finish; start wins over a done pulse.
		if (disinf_done) begin
			next_st.d_run = 1'b0;
		end
		if (d_fire) begin
			next_st.d_start = 1'b1;
			next_st.d_run   = 1'b1;
		end

		// Temperature check: full hot, then full cold, one sample each.
		case (st.tc)
			TC_IDLE: begin
				if (tc_fire) begin
					next_st.tc     = TC_HOT;
					next_st.tc_hot = 1'b1;
				end
			end
			TC_HOT: begin
				if (tc_sample) begin
					next_st.tc_hot_r = tc_temp;
					next_st.tc       = TC_COLD;
					next_st.tc_hot   = 1'b0;
					next_st.tc_cold  = 1'b1;
				end
			end
			TC_COLD: begin
				if (tc_sample) begin
					next_st.tc_cold_r = tc_temp;
					next_st.tc        = TC_IDLE;
					next_st.tc_cold   = 1'b0;
				end
			end
			default: begin
				next_st.tc      = TC_IDLE;
				next_st.tc_hot  = 1'b0;
				next_st.tc_cold = 1'b0;
			end
		endcase

		// Register reads. Write-only registers read back as zero.
		if (reg_rd) begin
			next_st.ack   = 1'b1;
			next_st.exc   = EXC_NONE;
			next_st.rdata = RST_WORD;
			case (reg_addr)
				ADDR_TC_HOT_RESULT:   next_st.rdata = st.tc_hot_r;
				ADDR_TC_COLD_RESULT:  next_st.rdata = st.tc_cold_r;
				ADDR_FLUSH_STATUS:    next_st.rdata = {13'h0000, st.fstatus};
				ADDR_USAGE_SINCE:     next_st.rdata = usage_s;
				ADDR_REC_FIRST_INDEX: next_st.rdata = st.rec_index;
				ADDR_REC_COUNT:       next_st.rdata = st.rec_count;
				ADDR_VALVE_DISABLE:   next_st.rdata = {15'h0000, st.dis};
				ADDR_POST_COLD_TIME:  next_st.rdata = st.post_p;
				ADDR_COLD_SCHED_TYPE: next_st.rdata = {15'h0000, st.sched_p};
				ADDR_COLD_ACT_TIME:   next_st.rdata = {5'h00, st.act_p};
				ADDR_DISINF_ARM, ADDR_DISINF_TRIGGER, ADDR_DISINF_ABORT,
				ADDR_VALVE_RESET, ADDR_TC_TRIGGER, ADDR_TC_ARM,
				ADDR_DUTY_TRIGGER, ADDR_COLD_TRIGGER: begin
					next_st.rdata = RST_WORD;
				end
				default: next_st.exc = EXC_ILLEGAL_ADDR;
			endcase
		end

		// Register writes. A refused word changes nothing.
		if (reg_wr) begin
			next_st.ack   = 1'b1;
			next_st.exc   = EXC_NONE;
			next_st.rdata = RST_WORD;
			case (reg_addr)
				ADDR_DISINF_ARM: begin
					if (!disinf_enabled) begin
						next_st.exc = EXC_ILLEGAL_DATA;
					end
				end
				ADDR_DISINF_TRIGGER: begin
					if (!d_fire) begin
						next_st.exc = EXC_ILLEGAL_DATA;
					end
				end
				ADDR_DISINF_ABORT: begin
					if (reg_wdata == CMD_ONE) begin
						next_st.d_stop = st.d_run;
						next_st.d_run  = 1'b0;
					end else begin
						next_st.exc = EXC_ILLEGAL_DATA;
					end
				end
				ADDR_VALVE_RESET: begin
					if (reg_wdata == CMD_ONE) begin
						next_st.v_reset = 1'b1;
					end else begin
						next_st.exc = EXC_ILLEGAL_DATA;
					end
				end
				ADDR_TC_ARM: begin
					if (st.tc != TC_IDLE) begin
						next_st.exc = EXC_ILLEGAL_DATA;
					end
				end
				ADDR_TC_TRIGGER: begin
					if (!tc_fire) begin
						next_st.exc = EXC_ILLEGAL_DATA;
					end
				end
				ADDR_DUTY_TRIGGER: begin
					if (key_ok(reg_wdata, KEY_DUTY_FLUSH)) begin
						next_st.duty_go = 1'b1;
					end else begin
						next_st.exc = EXC_ILLEGAL_DATA;
					end
				end
				ADDR_COLD_TRIGGER: begin
					if (key_ok(reg_wdata, KEY_COLD_FLUSH)) begin
						next_st.cold_go = 1'b1;
						next_st.post_c  = st.post_p;
						next_st.sched_c = st.sched_p;
						next_st.act_c   = st.act_p;
					end else begin
						next_st.exc = EXC_ILLEGAL_DATA;
					end
				end
				ADDR_VALVE_DISABLE: begin
					if (in_range(reg_wdata, CMD_ONE)) begin
						next_st.dis = reg_wdata[0];
					end else begin
						next_st.exc = EXC_ILLEGAL_DATA;
					end
				end
				ADDR_POST_COLD_TIME: begin
					if (in_range(reg_wdata, POST_COLD_MAX)) begin
						next_st.post_p = reg_wdata;
					end else begin
						next_st.exc = EXC_ILLEGAL_DATA;
					end
				end
				ADDR_COLD_SCHED_TYPE: begin
					if (in_range(reg_wdata, CMD_ONE)) begin
						next_st.sched_p = reg_wdata[0];
					end else begin
						next_st.exc = EXC_ILLEGAL_DATA;
					end
				end
				ADDR_COLD_ACT_TIME: begin
					// Out-of-day minutes are refused rather than wrapped.
					if (in_range(reg_wdata, ACT_TIME_MAX)) begin
						next_st.act_p = reg_wdata[10:0];
					end else begin
						next_st.exc = EXC_ILLEGAL_DATA;
					end
				end
				default: next_st.exc = EXC_ILLEGAL_ADDR;
			endcase
		end
	end

	// ========================================================
	// State register and outputs.
	// ========================================================
	// All state freezes while the clock enable is low.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign reg_rdata        = st.rdata;
	assign reg_ack          = st.ack;
	assign reg_exc          = st.exc;
	assign disinf_start     = st.d_start;
	assign disinf_stop      = st.d_stop;
	assign disinf_running   = st.d_run;
	assign valve_reset      = st.v_reset;
	assign duty_flush_start = st.duty_go;
	assign cold_flush_start = st.cold_go;
	assign tc_drive_hot     = st.tc_hot;
	assign tc_drive_cold    = st.tc_cold;
	assign valve_disabled   = st.dis;
	assign cold_sched_on    = st.sched_c;
	assign cold_act_minutes = st.act_c;
	assign post_cold_secs   = st.post_c;

endmodule

// ==== sim/reg_master.sv ====
// Register port master standing in for the serial framing logic.
// Assumes one pulse a request and an answer one cycle after it.
`timescale 1ns/100ps
module reg_master (
	input  wire logic        clk_sys,
	input  wire logic        reg_ack,
	input  wire logic [15:0] reg_rdata,
	input  wire logic [7:0]  reg_exc,
	output logic             reg_rd = 1'b0,
	output logic             reg_wr = 1'b0,
	output logic [15:0]      reg_addr = 16'h0000,
	output logic [15:0]      reg_wdata = 16'h0000
);
	// Pulse one request, then take the answer at the next edge.
	// Released address and data lines show the inverse, so stale values cannot pass.
	task automatic xfer(input logic rd, input logic [15:0] a, d,
	                    output logic [15:0] q, output logic [7:0] e);
		@(posedge clk_sys);
		reg_rd <= rd;
		reg_wr <= !rd;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		@(posedge clk_sys);
		q = reg_ack ? reg_rdata : 16'hDEAD;
		e = reg_ack ? reg_exc : 8'hEE;
	endtask
endmodule

// ==== sim/valve_cmd_assertions.sv ====
// Checker of the bank's answers and keyed commands.
// Assumes it is bound into the bank and sees its ports.
`timescale 1ns/100ps
module valve_cmd_checker
	import valve_cmd_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        ce,
	input wire logic        reg_rd,
	input wire logic        reg_wr,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_ack,
	input wire logic [7:0]  reg_exc,
	input wire logic        disinf_enabled,
	input wire logic        disinf_start,
	input wire logic        disinf_stop,
	input wire logic        disinf_running,
	input wire logic        valve_reset,
	input wire logic        duty_flush_start,
	input wire logic        cold_flush_start
);
	// Short forms of a taken write, its address and its data.
	wire logic        wr = ce && reg_wr;
	wire logic [15:0] ad = reg_addr;
	wire logic [15:0] dt = reg_wdata;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_ack_next: assert property (ce && (reg_rd || reg_wr) |=> reg_ack)
		else $error("No answer after a request.");
	a_ack_cause: assert property (reg_ack |-> $past(wr || ce && reg_rd))
		else $error("Answer without a request.");
	a_disinf_key: assert property (
		disinf_start |-> $past(wr && ad == ADDR_DISINF_TRIGGER &&
		dt == KEY_DISINFECTION)) else $error("Unkeyed disinfection.");
	a_start_runs: assert property (disinf_start |-> disinf_running)
		else $error("Started but not running.");
	a_duty_key: assert property (
		duty_flush_start |-> $past(wr && ad == ADDR_DUTY_TRIGGER &&
		dt == KEY_DUTY_FLUSH)) else $error("Unkeyed duty flush.");
	a_cold_key: assert property (
		cold_flush_start |-> $past(wr && ad == ADDR_COLD_TRIGGER &&
		dt == KEY_COLD_FLUSH)) else $error("Unkeyed cold flush.");
	a_reset_one: assert property (
		valve_reset |-> $past(wr && ad == ADDR_VALVE_RESET &&
		dt == CMD_ONE)) else $error("Valve reset without command.");
	a_arm_refused: assert property (
		wr && ad == ADDR_DISINF_ARM && !disinf_enabled |=>
		reg_exc == EXC_ILLEGAL_DATA) else $error("Arm not refused.");
	a_abort_stops: assert property (
		wr && ad == ADDR_DISINF_ABORT && dt == CMD_ONE && disinf_running
		|=> disinf_stop && !disinf_running) else $error("No abort.");
endmodule
bind valve_command_register_map valve_cmd_checker chk_i (
	.clk_sys(clk_sys), .rst(rst), .ce(ce), .reg_rd(reg_rd),
	.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_ack(reg_ack), .reg_exc(reg_exc),
	.disinf_enabled(disinf_enabled), .disinf_start(disinf_start),
	.disinf_stop(disinf_stop), .disinf_running(disinf_running),
	.valve_reset(valve_reset), .duty_flush_start(duty_flush_start),
	.cold_flush_start(cold_flush_start));

// ==== sim/testbench.sv ====
// Self-checking bench for the valve command register bank.
// Assumes the master model and the bound checker beside it.
`timescale 1ns/100ps
module testbench;
	import valve_cmd_pkg::*;
	localparam int CPS = 10;
	localparam logic [7:0] X3 = EXC_ILLEGAL_DATA;
	logic clk_sys = 1'b0, rst = 1'b1, dis_en = 1'b0, act = 1'b0;
	logic f_end = 1'b0, f_skip = 1'b0, f_hot = 1'b0, tc_s = 1'b0;
	logic rd, wr, ack, run, hot, cold, sch, dis;
	logic [15:0] ad, wd, rdat, tc_t = 16'h0000, v, t;
	logic [10:0] mins;
	logic [7:0] exc;
	int err_count = 0, n_compared = 0, seed = 99712, i;
	initial forever #50 clk_sys = ~clk_sys;
	reg_master m (.clk_sys(clk_sys), .reg_ack(ack), .reg_rdata(rdat),
		.reg_exc(exc), .reg_rd(rd), .reg_wr(wr), .reg_addr(ad),
		.reg_wdata(wd));
	valve_command_register_map #(.CYCLES_PER_SEC(CPS)) dut (
		.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .reg_rd(rd),
		.reg_wr(wr), .reg_addr(ad), .reg_wdata(wd), .reg_rdata(rdat),
		.reg_ack(ack), .reg_exc(exc), .disinf_enabled(dis_en),
		.disinf_done(1'b0), .outlet_active(act), .flush_end(f_end),
		.flush_skipped(f_skip), .flush_no_hot(f_hot),
		.flush_no_flow(1'b0), .flush_cancelled(1'b0), .tc_sample(tc_s),
		.tc_temp(tc_t), .disinf_start(), .disinf_stop(),
		.disinf_running(run), .valve_reset(), .duty_flush_start(),
		.cold_flush_start(), .tc_drive_hot(hot), .tc_drive_cold(cold),
		.valve_disabled(dis), .cold_sched_on(sch),
		.cold_act_minutes(mins), .post_cold_secs());
	task automatic chk(input logic [15:0] g, e);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// One access through the master, answer word and code compared.
	task automatic acc(input logic r, input logic [15:0] a, d, q,
	                   input logic [7:0] e);
		logic [15:0] gq;
		logic [7:0]  ge;
		m.xfer(r, a, d, gq, ge);
		chk(gq, q);
		chk({8'h00, ge}, {8'h00, e});
	endtask
	task automatic stop_test;
		$display("errors %0d compared %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Whole seconds expected for a run of active cycles.
	function automatic logic [15:0] secs(input int n);
		return 16'(n / CPS);
	endfunction
	initial begin
		repeat (3000) @(posedge clk_sys);
		err_count++;
		stop_test;
	end
	initial begin
		v = 16'($random(seed));
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		acc(1, 16'h0001, 0, 0, EXC_ILLEGAL_ADDR);
		act <= 1'b1;
		repeat (3 * CPS + 4) @(posedge clk_sys);
		act <= 1'b0;
		acc(1, ADDR_USAGE_SINCE, 0, secs(3 * CPS + 4), 0);
		for (i = 0; i < 2; i++) begin
			f_skip <= (i == 0);
			f_hot <= (i == 1);
			f_end <= 1'b1;
			@(posedge clk_sys);
			f_end <= 1'b0;
			acc(1, ADDR_FLUSH_STATUS, 0, 16'(i ? FLUSH_NO_HOT :
				FLUSH_NOT_REQUIRED), 0);
			acc(1, ADDR_REC_COUNT, 0, 16'(i + 1), 0);
			acc(1, ADDR_REC_FIRST_INDEX, 0, 16'(i), 0);
		end
		acc(1, ADDR_USAGE_SINCE, 0, 0, 0);
		acc(0, ADDR_DISINF_ARM, v, 0, X3);
		dis_en <= 1'b1;
		acc(0, ADDR_DISINF_TRIGGER, KEY_DISINFECTION, 0, X3);
		acc(0, ADDR_DISINF_ARM, v, 0, 0);
		acc(0, ADDR_DISINF_TRIGGER, KEY_DISINFECTION ^ (v | 1), 0, X3);
		acc(0, ADDR_DISINF_TRIGGER, KEY_DISINFECTION, 0, 0);
		chk({15'h0, run}, 1);
		acc(0, ADDR_DISINF_ABORT, 1, 0, 0);
		chk({15'h0, run}, 0);
		acc(0, ADDR_VALVE_RESET, 1, 0, 0);
		acc(0, ADDR_DUTY_TRIGGER, v & 16'h00FF, 0, X3);
		acc(0, ADDR_DUTY_TRIGGER, KEY_DUTY_FLUSH, 0, 0);
		acc(0, ADDR_TC_TRIGGER, KEY_TEMP_CHECK, 0, X3);
		acc(0, ADDR_TC_ARM, v, 0, 0);
		acc(0, ADDR_TC_TRIGGER, KEY_TEMP_CHECK, 0, 0);
		chk({15'h0, hot}, 1);
		for (i = 0; i < 2; i++) begin
			tc_t <= v + 16'(i);
			tc_s <= 1'b1;
			@(posedge clk_sys);
			tc_s <= 1'b0;
			@(posedge clk_sys);
			chk({14'h0, hot, cold}, 16'(i == 0));
		end
		acc(1, ADDR_TC_HOT_RESULT, 0, v, 0);
		acc(1, ADDR_TC_COLD_RESULT, 0, v + 1, 0);
		t = 16'($unsigned($random(seed)) % 1440);
		acc(0, ADDR_COLD_ACT_TIME, t, 0, 0);
		acc(0, ADDR_COLD_SCHED_TYPE, 1, 0, 0);
		acc(1, ADDR_COLD_ACT_TIME, 0, t, 0);
		chk({15'h0, sch}, 0);
		acc(0, ADDR_COLD_TRIGGER, KEY_COLD_FLUSH, 0, 0);
		chk({4'h0, sch, mins}, {4'h1, t[10:0]});
		acc(0, ADDR_COLD_ACT_TIME, ACT_TIME_MAX + 1, 0, X3);
		acc(0, ADDR_VALVE_DISABLE, 1, 0, 0);
		chk({15'h0, dis}, 1);
		stop_test;
	end
endmodule
